// ==== bmr_pkg.sv ====
/*
  Constants, types and register map of the read-side bus-matching FIFO block.
  Assumes one clock for the write port, the read port and the AHB-Lite slave.
*/
// Summary of operation
// RQ1 - With bus matching off, every read presents the whole 36-bit long word unchanged.
// RQ2 - In word width a long word takes two reads on lines 17..0, A,B then C,D or the reverse.
// RQ3 - In byte width a long word takes four reads on lines 8..0, A to D or D to A.
// RQ4 - In word width read lines 18 to 35 carry no defined value.
// RQ5 - In byte width read lines 9 to 35 carry no defined value.
// RQ6 - Byte order is caught at reset and held; width selects stay static outside.
// RQ7 - In fall-through mode a write to an empty FIFO raises output_ready on the second cycle after the write.
// RQ8 - In word or byte width only the final piece of a long word lowers the empty flags.
// RQ9 - In standard mode a write to an empty FIFO raises empty_flag_n on the next cycle.
// RQ10 - In fall-through mode a read from a full FIFO raises input_ready on the next cycle.
// RQ11 - In standard mode a read from a full FIFO raises full_flag_n on the next cycle.
// RQ12 - In word or byte width only the final piece read frees space in memory.
// RQ13 - The almost flags rise on the cycle after the qualifying write or read.
// RQ14 - Read width follows the static size and bus-match selects: 36, 18 or 9 bits.
// RQ15 - Memory is read a long word at a time; the remaining pieces wait in a holding register.
// RQ16 - After the final piece the next read fetches a new long word and restarts at piece one.
package bmr_pkg;

  // ==========================================================
  // widths and sizes
  localparam int LW_W      = 36;
  localparam int WORD_W    = 18;
  localparam int BYTE_W    = 9;
  localparam int DEPTH_DEF = 4096;
  localparam int DEPTH_MAX = 32768;
  localparam int OFS_DEF   = 8;
  localparam int AHB_DW    = 32;
  localparam int ADEC_W    = 8;

  // ==========================================================
  // register map, byte addresses
  localparam logic [ADEC_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADEC_W-1:0] REG_STATUS   = 8'h04;
  localparam logic [ADEC_W-1:0] REG_LEVEL    = 8'h08;
  localparam logic [ADEC_W-1:0] REG_AE_OFS   = 8'h0c;
  localparam logic [ADEC_W-1:0] REG_AF_OFS   = 8'h10;
  localparam logic [ADEC_W-1:0] REG_INT_STAT = 8'h14;
  localparam logic [ADEC_W-1:0] REG_INT_MASK = 8'h18;

  localparam int CTRL_FALL_THROUGH_MODE_BIT = 0;

  localparam int ST_EF        = 0;
  localparam int ST_OR        = 1;
  localparam int ST_FF        = 2;
  localparam int ST_IR        = 3;
  localparam int ST_AE        = 4;
  localparam int ST_AF        = 5;
  localparam int ST_BE        = 6;
  localparam int ST_SIZE_LSB  = 7;

  localparam int INT_W        = 4;
  localparam int INT_OVERFLOW = 0;
  localparam int INT_UNDERRUN = 1;
  localparam int INT_AE_FALL  = 2;
  localparam int INT_AF_FALL  = 3;

  localparam int HTRANS_ACT_BIT = 1;

  // ==========================================================
  // piece indices
  localparam logic [1:0] IDX_FIRST     = 2'h0;
  localparam logic [1:0] IDX_LAST_LONG = 2'h0;
  localparam logic [1:0] IDX_LAST_WORD = 2'h1;
  localparam logic [1:0] IDX_LAST_BYTE = 2'h3;

  // ==========================================================
  // types
  typedef enum logic [1:0] {BMR_SIZE_LONG, BMR_SIZE_WORD, BMR_SIZE_BYTE} bmr_size_t;

  typedef struct packed {
    logic            en;
    logic [LW_W-1:0] data;
  } bmr_wr_t;

  typedef struct packed {
    logic empty_flag_n;
    logic output_ready;
    logic full_flag_n;
    logic input_ready;
    logic almost_empty_n;
    logic almost_full_n;
  } bmr_flags_t;

endpackage

// ==== bmr_read_match.sv ====
/*
  Long-word FIFO with read-side bus matching, flag generation and an AHB-Lite
  register slave with a masked, sticky interrupt.
  Assumes write port, read port and bus all run on CLK; width selects are static.
*/
`timescale 1ns/1ns
module bmr_read_match
#(
  parameter int DEPTH = bmr_pkg::DEPTH_DEF
)
(
  input  wire logic                          CLK,
  input  wire logic                          RESETN,
  input  wire logic                          HSEL,
  input  wire logic [31:0]                   HADDR,
  input  wire logic [1:0]                    HTRANS,
  input  wire logic                          HWRITE,
  input  wire logic [2:0]                    HSIZE,
  input  wire logic [bmr_pkg::AHB_DW-1:0]    HWDATA,
  input  wire logic                          HREADY,
  output logic [bmr_pkg::AHB_DW-1:0]         HRDATA,
  output logic                               HREADYOUT,
  output logic                               HRESP,
  input  wire bmr_pkg::bmr_wr_t              WRITE_PORT,
  input  wire logic                          READ_ENABLE,
  input  wire logic                          BUS_MATCH_SELECT,
  input  wire logic                          SIZE_SELECT,
  input  wire logic                          BYTE_ORDER_SELECT,
  output logic [bmr_pkg::LW_W-1:0]           READ_DATA,
  output bmr_pkg::bmr_flags_t                FLAGS,
  output logic                               IRQ
);
  import bmr_pkg::*;

  localparam int AW    = $clog2(DEPTH);
  localparam int CNT_W = AW + 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] OFS_RST = CNT_W'(OFS_DEF);

  generate
    if (DEPTH < 4 || DEPTH > DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("DEPTH must be a power of two from 4 to 32768");
    end
  endgenerate

  // ==========================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ==========================================================
  // configuration caught once after reset
  logic      cfg_done_reg;
  logic      be_reg;
  bmr_size_t size_reg;
  bmr_size_t size_pin;

  assign size_pin = !BUS_MATCH_SELECT ? BMR_SIZE_LONG :
                    (SIZE_SELECT ? BMR_SIZE_BYTE : BMR_SIZE_WORD); // RQ14

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      cfg_done_reg <= 1'b0;
      be_reg       <= 1'b0;
      size_reg     <= BMR_SIZE_LONG;
    end
    else if (!cfg_done_reg)
    begin
      // later changes on the pins are ignored until the next reset
      cfg_done_reg <= 1'b1;
      be_reg       <= BYTE_ORDER_SELECT; // RQ6
      size_reg     <= size_pin; // RQ6
    end
  end

  // ==========================================================
  // storage and pointers
  logic [LW_W-1:0]  mem [DEPTH];
  logic [CNT_W-1:0] wr_ptr_reg;
  logic [CNT_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] avail;
  logic [1:0]       idx_reg;
  logic [1:0]       idx_next;
  logic [1:0]       idx_last;
  logic [1:0]       byte_sel;
  logic [LW_W-1:0]  lw_reg;
  logic [LW_W-1:0]  src;
  logic [LW_W-1:0]  piece;
  logic [LW_W-1:0]  out_reg;
  logic             or_reg;
  logic             or_next;
  logic             fall_through_mode_reg;
  logic [CNT_W-1:0] ae_ofs_reg;
  logic [CNT_W-1:0] af_ofs_reg;
  bmr_flags_t       flags_reg;
  bmr_flags_t       flags_next;

  logic wr_go;
  logic std_present;
  logic fw_present;
  logic present;
  logic fetch;
  logic pop;
  logic half_hi;
  logic overflow;
  logic underrun;

  // ==========================================================
  // read sequencing
  assign idx_last = (size_reg == BMR_SIZE_LONG) ? IDX_LAST_LONG :
                    (size_reg == BMR_SIZE_WORD) ? IDX_LAST_WORD : IDX_LAST_BYTE;
  assign avail    = wr_ptr_reg - rd_ptr_reg;
  assign wr_go    = WRITE_PORT.en & flags_reg.full_flag_n;
  assign overflow = WRITE_PORT.en & ~flags_reg.full_flag_n;
  assign underrun = READ_ENABLE & ~(fall_through_mode_reg ? or_reg : flags_reg.empty_flag_n);

  assign std_present = READ_ENABLE & flags_reg.empty_flag_n;
  // fall-through keeps the output register filled without a read
  assign fw_present  = (~or_reg | READ_ENABLE) &
                       ((idx_reg != IDX_FIRST) | (avail != '0)); // RQ7
  assign present     = fall_through_mode_reg ? fw_present : std_present;
  assign fetch       = present & (idx_reg == IDX_FIRST); // RQ15 RQ16
  // space is freed only when the final piece leaves the port
  assign pop = fall_through_mode_reg ? (READ_ENABLE & or_reg & (idx_reg == IDX_FIRST))
                        : (std_present & (idx_reg == idx_last)); // RQ8 RQ12
  assign count_next = count_reg + CNT_W'(wr_go) - CNT_W'(pop);

  assign idx_next = !present ? idx_reg :
                    (idx_reg == idx_last) ? IDX_FIRST : idx_reg + 2'h1; // RQ16
  assign or_next  = fall_through_mode_reg & (present | (or_reg & ~READ_ENABLE)); // RQ7

  // ==========================================================
  // bus matching
  assign src      = (idx_reg == IDX_FIRST) ? mem[rd_ptr_reg[AW-1:0]] : lw_reg; // RQ15
  assign byte_sel = be_reg ? ~idx_reg : idx_reg; // RQ3
  assign half_hi  = be_reg ? (idx_reg == IDX_FIRST) : (idx_reg != IDX_FIRST); // RQ2
  // unused upper lanes are driven low; their value is not defined to the reader
  assign piece = (size_reg == BMR_SIZE_LONG) ? src : // RQ1
                 (size_reg == BMR_SIZE_WORD) ?
                   {{(LW_W-WORD_W){1'b0}},
                    (half_hi ? src[LW_W-1:WORD_W] : src[WORD_W-1:0])} : // RQ4
                   {{(LW_W-BYTE_W){1'b0}}, src[BYTE_W*byte_sel +: BYTE_W]}; // RQ5

  // ==========================================================
  // flags from the next fill level and or_next, so they move on the following edge
  assign flags_next.empty_flag_n   = count_next != '0; // RQ9
  assign flags_next.output_ready   = or_next;
  assign flags_next.full_flag_n    = count_next != DEPTH_C; // RQ11
  assign flags_next.input_ready    = fall_through_mode_reg & (count_next != DEPTH_C); // RQ10
  assign flags_next.almost_empty_n = count_next > ae_ofs_reg; // RQ13
  assign flags_next.almost_full_n  = count_next < (DEPTH_C - af_ofs_reg); // RQ13

  always_ff @(posedge CLK)
  begin
    if (wr_go)
      mem[wr_ptr_reg[AW-1:0]] <= WRITE_PORT.data;
  end

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      idx_reg    <= IDX_FIRST;
      or_reg     <= 1'b0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + CNT_W'(wr_go);
      rd_ptr_reg <= rd_ptr_reg + CNT_W'(fetch);
      count_reg  <= count_next;
      idx_reg    <= idx_next;
      or_reg     <= or_next;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      lw_reg    <= '0;
      out_reg   <= '0;
      flags_reg <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    end
    else
    begin
      lw_reg    <= fetch ? src : lw_reg; // RQ15
      out_reg   <= present ? piece : out_reg;
      flags_reg <= flags_next;
    end
  end

  // ==========================================================
  // ahb-lite slave, zero wait states
  logic [ADEC_W-1:0]  a_addr_reg;
  logic               a_wr_reg;
  logic [AHB_DW-1:0]  rdata_reg;
  logic [AHB_DW-1:0]  rd_mux;
  logic [AHB_DW-1:0]  status_word;
  logic [INT_W-1:0]   stat_reg;
  logic [INT_W-1:0]   stat_next;
  logic [INT_W-1:0]   mask_reg;
  logic [INT_W-1:0]   events;
  logic               irq_reg;
  logic               take;
  logic               wr_ctrl;
  logic               wr_ae;
  logic               wr_af;
  logic               wr_stat;
  logic               wr_mask;

  assign take    = HSEL & HTRANS[HTRANS_ACT_BIT] & HREADY;
  assign wr_ctrl = a_wr_reg & (a_addr_reg == REG_CTRL);
  assign wr_ae   = a_wr_reg & (a_addr_reg == REG_AE_OFS);
  assign wr_af   = a_wr_reg & (a_addr_reg == REG_AF_OFS);
  assign wr_stat = a_wr_reg & (a_addr_reg == REG_INT_STAT);
  assign wr_mask = a_wr_reg & (a_addr_reg == REG_INT_MASK);

  assign status_word = AHB_DW'({logic'(size_reg == BMR_SIZE_BYTE),
                                logic'(size_reg == BMR_SIZE_WORD), be_reg,
                                flags_reg.almost_full_n, flags_reg.almost_empty_n,
                                flags_reg.input_ready, flags_reg.full_flag_n,
                                flags_reg.output_ready, flags_reg.empty_flag_n});

  assign rd_mux = (HADDR[ADEC_W-1:0] == REG_CTRL)     ? AHB_DW'(fall_through_mode_reg) :
                  (HADDR[ADEC_W-1:0] == REG_STATUS)   ? status_word :
                  (HADDR[ADEC_W-1:0] == REG_LEVEL)    ? AHB_DW'(count_reg) :
                  (HADDR[ADEC_W-1:0] == REG_AE_OFS)   ? AHB_DW'(ae_ofs_reg) :
                  (HADDR[ADEC_W-1:0] == REG_AF_OFS)   ? AHB_DW'(af_ofs_reg) :
                  (HADDR[ADEC_W-1:0] == REG_INT_STAT) ? AHB_DW'(stat_reg) :
                  (HADDR[ADEC_W-1:0] == REG_INT_MASK) ? AHB_DW'(mask_reg) : '0;

  assign events[INT_OVERFLOW] = overflow;
  assign events[INT_UNDERRUN] = underrun;
  assign events[INT_AE_FALL]  = flags_reg.almost_empty_n & ~flags_next.almost_empty_n;
  assign events[INT_AF_FALL]  = flags_reg.almost_full_n & ~flags_next.almost_full_n;
  // a new event beats a write-one-to-clear in the same cycle
  assign stat_next = (stat_reg & ~(wr_stat ? HWDATA[INT_W-1:0] : '0)) | events;

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      a_addr_reg <= '0;
      a_wr_reg   <= 1'b0;
      rdata_reg  <= '0;
    end
    else
    begin
      a_addr_reg <= take ? HADDR[ADEC_W-1:0] : a_addr_reg;
      a_wr_reg   <= take & HWRITE;
      rdata_reg  <= (take & ~HWRITE) ? rd_mux : '0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      fall_through_mode_reg   <= 1'b0;
      ae_ofs_reg <= OFS_RST;
      af_ofs_reg <= OFS_RST;
      mask_reg   <= '0;
      stat_reg   <= '0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      fall_through_mode_reg   <= wr_ctrl ? HWDATA[CTRL_FALL_THROUGH_MODE_BIT] : fall_through_mode_reg;
      ae_ofs_reg <= wr_ae ? HWDATA[CNT_W-1:0] : ae_ofs_reg;
      af_ofs_reg <= wr_af ? HWDATA[CNT_W-1:0] : af_ofs_reg;
      mask_reg   <= wr_mask ? HWDATA[INT_W-1:0] : mask_reg;
      stat_reg   <= stat_next;
      irq_reg    <= |(stat_next & mask_reg);
    end
  end

  // ==========================================================
  // outputs
  assign HRDATA    = rdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign READ_DATA = out_reg;
  assign FLAGS     = flags_reg;
  assign IRQ       = irq_reg;

endmodule

// ==== bmr_far_side.sv ====
/*
  Far-side model: the write-port pusher and the read-port puller.
  Assumes callers enter its tasks just after a rising clk edge.
*/
`timescale 1ns/1ns
module bmr_far_side
(
  input  wire logic        clk,
  output bmr_pkg::bmr_wr_t wr,
  output logic             rd_en
);
  import bmr_pkg::*;

  // ==========================================================
  // requests
  initial
  begin
    wr = '0;
    rd_en = 1'b0;
  end

  // one whole long word per request
  task automatic push(input logic [LW_W-1:0] d, input logic hold);
    wr <= '{en: 1'b1, data: d};
    @(posedge clk);
    // released lines show the inverse so a stale word cannot pass
    if (!hold)
      wr <= '{en: 1'b0, data: ~d};
  endtask

  task automatic pull(input logic hold);
    rd_en <= 1'b1;
    @(posedge clk);
    if (!hold)
      rd_en <= 1'b0;
  endtask
endmodule

// ==== bmr_read_match_assertions.sv ====
/*
  Port checker for bmr_read_match, bound to every instance.
  Assumes one clock CLK and the active-low reset RESETN.
*/
`timescale 1ns/1ns
module bmr_checker
#(
  parameter int DEPTH = bmr_pkg::DEPTH_DEF
)
(
  input wire logic                CLK,
  input wire logic                RESETN,
  input wire bmr_pkg::bmr_wr_t    WRITE_PORT,
  input wire logic                READ_ENABLE,
  input wire logic [35:0]         READ_DATA,
  input wire bmr_pkg::bmr_flags_t FLAGS,
  input wire logic                IRQ
);
  import bmr_pkg::*;

  // ==========================================================
  // flag and data relations
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  a_empty_rise:
    assert property (WRITE_PORT.en && FLAGS.full_flag_n && !FLAGS.empty_flag_n
      |=> FLAGS.empty_flag_n) else $error("empty flag missed a write");
  a_empty_fall:
    assert property ($fell(FLAGS.empty_flag_n) |-> $past(READ_ENABLE))
      else $error("empty flag fell without a read");
  a_full_fall:
    assert property ($fell(FLAGS.full_flag_n) |-> $past(WRITE_PORT.en))
      else $error("full flag fell without a write");
  a_full_rise:
    assert property ($rose(FLAGS.full_flag_n) |-> $past(READ_ENABLE))
      else $error("full flag rose without a read");
  a_ae_rise:
    assert property ($rose(FLAGS.almost_empty_n) |-> $past(WRITE_PORT.en))
      else $error("almost empty rose without a write");
  a_af_rise:
    assert property ($rose(FLAGS.almost_full_n) |-> $past(READ_ENABLE))
      else $error("almost full rose without a read");
  a_ready_out_rise:
    assert property ($rose(FLAGS.output_ready) |-> $past(WRITE_PORT.en, 2))
      else $error("output ready rose without a write");
  a_data_hold:
    assert property (!READ_ENABLE && !WRITE_PORT.en && !$past(WRITE_PORT.en)
      |=> $stable(READ_DATA)) else $error("read data moved without a read");

  cover property ($rose(FLAGS.full_flag_n));
  cover property ($rose(FLAGS.output_ready));
  cover property ($rose(IRQ));
endmodule

bind bmr_read_match bmr_checker #(.DEPTH(DEPTH)) i_bmr_checker (
  .CLK(CLK), .RESETN(RESETN), .WRITE_PORT(WRITE_PORT), .READ_ENABLE(READ_ENABLE),
  .READ_DATA(READ_DATA), .FLAGS(FLAGS), .IRQ(IRQ));

// ==== bmr_read_match_tb.sv ====
/*
  Self-checking bench for bmr_read_match: all width modes, all flags, every register except REG_AF_OFS.
  Assumes bmr_far_side and the bound checker; one clock for everything.
*/
`timescale 1ns/1ns
module bmr_read_match_tb;
  import bmr_pkg::*;
  localparam int DP = 16;

  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic                hsel = 1'b0;
  logic                hwrite = 1'b0;
  logic [1:0]          htrans = 2'h0;
  logic [31:0]         haddr = 32'h0;
  logic [31:0]         hwdata = 32'h0;
  logic [31:0]         hrdata;
  logic                hready;
  logic                hresp;
  logic                irq;
  logic                rd_en;
  logic                bm = 1'b0;
  logic                sz = 1'b0;
  logic                be = 1'b0;
  logic                ft = 1'b0;
  logic                took = 1'b0;
  logic [31:0]         seed = 32'h59e19ff4;
  logic [35:0]         d;
  logic [35:0]         msk;
  logic [35:0]         rd_data;
  logic [35:0]         exp_q[$];
  logic [2:0]          modes[5] = '{3'h0, 3'h5, 3'h4, 3'h7, 3'h6};
  bmr_wr_t             wr;
  bmr_flags_t          flags;
  int                  np;
  int                  bad_count = 0;
  int                  tests_run = 0;

  always #2 clk = ~clk;

  bmr_read_match #(.DEPTH(DP)) i_bmr_read_match (.CLK(clk), .RESETN(resetn),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .WRITE_PORT(wr), .READ_ENABLE(rd_en), .BUS_MATCH_SELECT(bm),
    .SIZE_SELECT(sz), .BYTE_ORDER_SELECT(be), .READ_DATA(rd_data), .FLAGS(flags),
    .IRQ(irq));
  bmr_far_side i_bmr_far_side (.clk(clk), .wr(wr), .rd_en(rd_en));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // piece i of long word w in the current width and order
  function automatic logic [35:0] piece(input logic [35:0] w, input int i);
    int k;
    k = be ? i : np - 1 - i;
    if (np == 1)
      return w;
    if (np == 2)
      return {18'h0, w[35 - 18 * k -: 18]};
    return {27'h0, w[35 - 9 * k -: 9]};
  endfunction

  task automatic check(input string n, input logic [35:0] e, input logic [35:0] s);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", 36'h0, 36'(hresp));
  endtask

  // selects held steady through reset and after
  task automatic rst(input logic [2:0] m);
    resetn <= 1'b0;
    {bm, sz, be} <= m;
    np = m[2] ? (m[1] ? 4 : 2) : 1;
    msk = m[2] ? (m[1] ? 36'h1ff : 36'h3ffff) : 36'hfffffffff;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic put(input logic hold, input logic keep);
    seed = lfsr(seed);
    d = {seed[3:0], seed};
    if (keep)
      for (int i = 0; i < np; i++)
        exp_q.push_back(piece(d, i));
    i_bmr_far_side.push(d, hold);
  endtask

  task automatic drain(input int n);
    for (int i = 0; i < n; i++)
      i_bmr_far_side.pull(i < n - 1);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // read scoreboard, standard mode
  always @(posedge clk)
    took <= rd_en && flags.empty_flag_n && !ft;

  always @(negedge clk)
    if (took && exp_q.size() > 0)
    begin
      check("read piece", exp_q.pop_front() & msk, rd_data & msk);
      check("empty flag", 36'(exp_q.size() != 0), 36'(flags.empty_flag_n));
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    stop_test;
  end

  // ==========================================================
  // scenarios
  initial
  begin
    logic [31:0] r;
    foreach (modes[m])
    begin
      rst(modes[m]);
      put(1'b0, 1'b1);
      @(negedge clk);
      check("empty rise", 36'h1, 36'(flags.empty_flag_n));
      @(posedge clk);
      put(1'b0, 1'b1);
      drain(2 * np);
      @(posedge clk);
      drain(1);
    end
    @(posedge clk);
    for (int i = 0; i <= DP; i++)
      put(i < DP, i < DP);
    @(negedge clk);
    check("full low", 36'h0, 36'(flags.full_flag_n));
    check("almost full", 36'h0, 36'(flags.almost_full_n));
    check("almost empty", 36'h1, 36'(flags.almost_empty_n));
    @(posedge clk);
    ahb(1'b0, REG_LEVEL, 32'h0, r);
    check("level", 36'(DP), 36'(r));
    @(posedge clk);
    drain(np - 1);
    @(negedge clk);
    check("full held", 36'h0, 36'(flags.full_flag_n));
    @(posedge clk);
    drain(1);
    @(negedge clk);
    check("full rise", 36'h1, 36'(flags.full_flag_n));
    @(posedge clk);
    drain((DP - 1) * np);
    @(posedge clk);
    drain(1);
    ahb(1'b0, REG_INT_STAT, 32'h0, r);
    check("int status", 36'hf, 36'(r[INT_W-1:0]));
    check("irq masked", 36'h0, 36'(irq));
    ahb(1'b1, REG_INT_MASK, 32'h3, r);
    repeat (2) @(posedge clk);
    check("irq raised", 36'h1, 36'(irq));
    ahb(1'b1, REG_INT_STAT, 32'hf, r);
    repeat (2) @(posedge clk);
    check("irq cleared", 36'h0, 36'(irq));
    ahb(1'b0, 8'h40, 32'h0, r);
    check("unmapped", 36'h0, 36'(r));
    ahb(1'b0, REG_AE_OFS, 32'h0, r);
    check("ae offset", 36'h8, 36'(r));
    rst(3'h0);
    ft <= 1'b1;
    ahb(1'b0, REG_CTRL, 32'h0, r);
    check("ctrl reset", 36'h0, 36'(r));
    ahb(1'b1, REG_CTRL, 32'h1, r);
    @(posedge clk);
    put(1'b0, 1'b0);
    repeat (2) @(negedge clk);
    check("ready out", 36'h1, 36'(flags.output_ready));
    check("fall data", d, rd_data);
    check("ready in", 36'h1, 36'(flags.input_ready));
    @(posedge clk);
    ahb(1'b0, REG_STATUS, 32'h0, r);
    check("status", 36'h2f, 36'(r));
    drain(1);
    @(negedge clk);
    check("ready out low", 36'h0, 36'(flags.output_ready));
    stop_test;
  end
endmodule
